// *** spf_pkg.sv ***
// Purpose: Shared constants and carrier types for the serial-port error checks.
// Assumes: 8-bit command byte followed by one 16-bit data word per access.
// Notes: Register offsets and control bit positions not fixed elsewhere are local choices.
package spf_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int CMD_W = 8;
  localparam int WORD_W = CMD_W + DATA_W;
  localparam logic [4:0] POS_CMD_LAST = 5'h07;
  localparam logic [4:0] POS_WORD_LAST = 5'h17;
  localparam logic [4:0] POS_DATA_FIRST = 5'h08;
  localparam logic [4:0] POS_ZERO = 5'h00;
  localparam logic [4:0] POS_ONE = 5'h01;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [2:0] BYTE_REM_ZERO = 3'h0;
  localparam int CMD_READ_BIT = 6;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_BUSY_STATUS = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_ERROR = 6'h06;
  localparam logic [ADDR_W-1:0] ADDR_ERROR_ENABLE = 6'h07;
  localparam int CTRL_FRAMING_BIT = 8;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ERR_EN_RESET = 16'h0040;
  localparam int EN_BUSY_WRITE_BIT = 6;
  localparam int EN_CLOCK_COUNT_BIT = 5;
  localparam int EN_INVALID_READ_BIT = 4;
  localparam int EN_INVALID_WRITE_BIT = 3;
  localparam int STAT_FUSE_BIT = 0;
  localparam int STAT_CAL_BIT = 1;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CMD_W-1:0] cmd;
    logic [DATA_W-1:0] data;
  } spf_word_s;

  // Same order as the enable bits, so the flags sit at bits 6..3
  typedef struct packed {
    logic busy_write;
    logic clock_count_flag;
    logic invalid_read;
    logic invalid_write;
  } spf_flags_s;

endpackage

// *** spf_error_checks.sv ***
// Purpose: Serial register port with busy-write, clock-count, invalid-read and
//   invalid-write checks, sticky error flags and their enables.
// Assumes: Host samples on rising sclk, device drives miso on falling sclk;
//   busy inputs come from logic on clk.
// Notes: Shift logic runs on sclk; registers and flags live on clk.
//
// Contract
// - Busy-write check enable is bit 6 and resets to one.
// - Enabled busy check flags writes made while fuses are being copied.
// - Enabled busy check flags writes made during offset or gain calibration.
// - Clock-count check is bit 5 and needs select framing enabled.
// - Active clock-count check flags framed accesses whose clock count is not byte multiple.
// - Short framed writes are discarded and leave the target register unchanged.
// - Invalid-read check is bit 4, needs framing, flags reads of missing addresses.
// - Invalid-write check is bit 3 and needs select framing enabled.
// - Active invalid-write check flags writes to missing or read-only addresses.
// - Clock-count, invalid-read and invalid-write enables reset to zero.
// - Accesses are whole eight-clock bytes on both sides.
module spf_error_checks (
  // System
  input wire logic clk,
  input wire logic reset,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // Busy indications from the fuse-copy and calibration engines
  input wire logic fuse_copy_busy,
  input wire logic calibration_busy,
  // Register state
  output spf_pkg::spf_flags_s error_flags,
  output logic [spf_pkg::DATA_W-1:0] error_report_enable,
  output logic [spf_pkg::DATA_W-1:0] control_word
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic is_readable(input logic [spf_pkg::ADDR_W-1:0] a);
    is_readable = (a == spf_pkg::ADDR_CONTROL) || (a == spf_pkg::ADDR_BUSY_STATUS) ||
                  (a == spf_pkg::ADDR_ERROR) || (a == spf_pkg::ADDR_ERROR_ENABLE);
  endfunction

  function automatic logic is_writable(input logic [spf_pkg::ADDR_W-1:0] a);
    is_writable = (a == spf_pkg::ADDR_CONTROL) || (a == spf_pkg::ADDR_ERROR_ENABLE);
  endfunction

  // Register state on clk, read by the shift logic
  logic [spf_pkg::DATA_W-1:0] ctrl_reg;
  logic [spf_pkg::DATA_W-1:0] err_en_reg;
  logic [spf_pkg::DATA_W-1:0] shadow_err_reg;
  logic [spf_pkg::DATA_W-1:0] shadow_stat_reg;
  spf_pkg::spf_flags_s flags_reg;

  // ----------------------------------------------------------------
  // Link side (sclk)
  // ----------------------------------------------------------------
  logic started_reg;
  logic [7:0] total_reg;
  logic [4:0] pos_reg;
  logic full_reg;
  logic [spf_pkg::WORD_W-2:0] shift_reg;
  logic [spf_pkg::CMD_W-1:0] cmd_reg;
  spf_pkg::spf_word_s word_reg;
  logic word_tgl_reg;
  logic frame_tgl_reg;
  logic [spf_pkg::DATA_W-1:0] tx_reg;
  logic miso_reg;
  logic miso_oe_n_reg;
  logic [4:0] pos_cur;
  logic [spf_pkg::CMD_W-1:0] cmd_in;
  logic [spf_pkg::DATA_W-1:0] rd_mux;

  assign pos_cur = started_reg ? pos_reg : spf_pkg::POS_ZERO;
  assign cmd_in = {shift_reg[spf_pkg::CMD_W-2:0], mosi};

  // Chip select high clears only the frame-start marker and the miso registers; the counts stay
  // readable by clk after the frame, while sclk is stopped
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  // Total clock count of the frame, wraps; its low three bits give the byte remainder
  always_ff @(posedge sclk) begin
    if (!started_reg) begin
      total_reg <= spf_pkg::COUNT_ONE;
    end else begin
      total_reg <= total_reg + spf_pkg::COUNT_ONE;
    end
  end

  // Whole bytes only: a word is complete at the 24th clock and not before
  always_ff @(posedge sclk) begin
    shift_reg <= {shift_reg[spf_pkg::WORD_W-3:0], mosi};
    if (pos_cur == spf_pkg::POS_WORD_LAST) begin
      pos_reg <= spf_pkg::POS_ZERO;
      word_reg <= {shift_reg, mosi};
    end else begin
      pos_reg <= pos_cur + spf_pkg::POS_ONE;
    end
    if (pos_cur == spf_pkg::POS_CMD_LAST) begin
      cmd_reg <= cmd_in;
    end
  end

  always_ff @(posedge sclk) begin
    if (!started_reg) begin
      full_reg <= 1'b0;
    end else if (pos_cur == spf_pkg::POS_WORD_LAST) begin
      full_reg <= 1'b1;
    end
  end

  // Events for clk; reset is borrowed only to give the toggles a known start
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      word_tgl_reg <= 1'b0;
      frame_tgl_reg <= 1'b0;
    end else begin
      if (pos_cur == spf_pkg::POS_WORD_LAST) begin
        word_tgl_reg <= ~word_tgl_reg;
      end
      if (!started_reg) begin
        frame_tgl_reg <= ~frame_tgl_reg;
      end
    end
  end

  // Read data: with framing on, the status and error copies are frozen by clk while the frame is open
  always_comb begin
    unique case (cmd_in[spf_pkg::ADDR_W-1:0])
      spf_pkg::ADDR_CONTROL: rd_mux = ctrl_reg;
      spf_pkg::ADDR_BUSY_STATUS: rd_mux = shadow_stat_reg;
      spf_pkg::ADDR_ERROR: rd_mux = shadow_err_reg;
      spf_pkg::ADDR_ERROR_ENABLE: rd_mux = err_en_reg;
      default: rd_mux = spf_pkg::ZERO_WORD;
    endcase
  end

  always_ff @(posedge sclk) begin
    if (pos_cur == spf_pkg::POS_CMD_LAST) begin
      tx_reg <= rd_mux;
    end else begin
      tx_reg <= {tx_reg[spf_pkg::DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      miso_reg <= 1'b0;
      miso_oe_n_reg <= 1'b1;
    end else begin
      miso_reg <= tx_reg[spf_pkg::DATA_W-1];
      // A new frame's first falling edge must not reuse the last frame's state
      miso_oe_n_reg <= !(started_reg && cmd_reg[spf_pkg::CMD_READ_BIT] && !full_reg &&
                         (pos_reg >= spf_pkg::POS_DATA_FIRST));
    end
  end

  assign miso = miso_reg;
  assign miso_oe_n = miso_oe_n_reg;

  // ----------------------------------------------------------------
  // Crossings into clk
  // ----------------------------------------------------------------
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic wt_s1_reg, wt_s2_reg, wt_s3_reg;
  logic ft_s1_reg, ft_s2_reg, ft_seen_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      wt_s1_reg <= 1'b0;
      wt_s2_reg <= 1'b0;
      wt_s3_reg <= 1'b0;
      ft_s1_reg <= 1'b0;
      ft_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      wt_s1_reg <= word_tgl_reg;
      wt_s2_reg <= wt_s1_reg;
      wt_s3_reg <= wt_s2_reg;
      ft_s1_reg <= frame_tgl_reg;
      ft_s2_reg <= ft_s1_reg;
    end
  end

  logic frame_end;
  logic frame_clocked;
  logic word_evt;
  logic is_read;
  logic [spf_pkg::ADDR_W-1:0] w_addr;
  logic busy;

  assign frame_end = cs_s2_reg && !cs_s3_reg;
  // A frame with no clocks leaves total_reg from the previous frame
  assign frame_clocked = ft_s2_reg != ft_seen_reg;
  assign word_evt = wt_s2_reg != wt_s3_reg;
  assign is_read = word_reg.cmd[spf_pkg::CMD_READ_BIT];
  assign w_addr = word_reg.cmd[spf_pkg::ADDR_W-1:0];
  assign busy = fuse_copy_busy || calibration_busy;

  always_ff @(posedge clk) begin
    if (reset) begin
      ft_seen_reg <= 1'b0;
    end else if (frame_end) begin
      ft_seen_reg <= ft_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Check enables
  // ----------------------------------------------------------------
  logic framing_on, busy_chk, clk_chk, rd_chk, wr_chk;

  assign framing_on = ctrl_reg[spf_pkg::CTRL_FRAMING_BIT];
  assign busy_chk = err_en_reg[spf_pkg::EN_BUSY_WRITE_BIT];
  assign clk_chk = err_en_reg[spf_pkg::EN_CLOCK_COUNT_BIT] && framing_on;
  assign rd_chk = err_en_reg[spf_pkg::EN_INVALID_READ_BIT] && framing_on;
  assign wr_chk = err_en_reg[spf_pkg::EN_INVALID_WRITE_BIT] && framing_on;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic do_write;

  // Only a complete word can commit, so a short write never touches a register
  assign do_write = word_evt && !is_read && !busy && is_writable(w_addr);

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= spf_pkg::CTRL_RESET;
    end else if (do_write && (w_addr == spf_pkg::ADDR_CONTROL)) begin
      ctrl_reg <= word_reg.data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      err_en_reg <= spf_pkg::ERR_EN_RESET;
    end else if (do_write && (w_addr == spf_pkg::ADDR_ERROR_ENABLE)) begin
      err_en_reg <= word_reg.data;
    end
  end

  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  spf_pkg::spf_flags_s set_v;
  logic clr_v;

  always_comb begin
    set_v = '0;
    set_v.busy_write = word_evt && !is_read && busy && busy_chk;
    set_v.clock_count_flag = frame_end && frame_clocked && clk_chk &&
                             (total_reg[2:0] != spf_pkg::BYTE_REM_ZERO);
    set_v.invalid_read = word_evt && is_read && !is_readable(w_addr) && rd_chk;
    set_v.invalid_write = word_evt && !is_read && !busy && !is_writable(w_addr) &&
                          wr_chk;
  end

  assign clr_v = word_evt && is_read && (w_addr == spf_pkg::ADDR_ERROR);

  // Sticky; a set in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (clr_v ? '0 : flags_reg) | set_v;
    end
  end

  // Frozen copies for the shift logic; without framing they track freely
  always_ff @(posedge clk) begin
    if (reset) begin
      shadow_err_reg <= spf_pkg::ZERO_WORD;
      shadow_stat_reg <= spf_pkg::ZERO_WORD;
    end else if (cs_s2_reg || !framing_on) begin
      shadow_err_reg <= spf_pkg::ZERO_WORD;
      shadow_err_reg[spf_pkg::EN_BUSY_WRITE_BIT -: 4] <= flags_reg;
      shadow_stat_reg <= spf_pkg::ZERO_WORD;
      shadow_stat_reg[spf_pkg::STAT_FUSE_BIT] <= fuse_copy_busy;
      shadow_stat_reg[spf_pkg::STAT_CAL_BIT] <= calibration_busy;
    end
  end

  assign error_flags = flags_reg;
  assign error_report_enable = err_en_reg;
  assign control_word = ctrl_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_BUSY_EN_RESET: assert property (
    $fell(reset) |-> err_en_reg[spf_pkg::EN_BUSY_WRITE_BIT])
    else $error("busy-write enable not set after reset");
  AST_OTHER_EN_RESET: assert property (
    $fell(reset) |-> (err_en_reg[5:3] == 3'h0) ##1 !$rose(flags_reg.clock_count_flag))
    else $error("check enables not clear after reset");
  AST_BUSY_FUSE: assert property (
    word_evt && !is_read && fuse_copy_busy && busy_chk
      |=> flags_reg.busy_write && $stable(ctrl_reg) && $stable(err_en_reg))
    else $error("write during fuse copy not flagged or not ignored");
  AST_BUSY_CAL: assert property (
    word_evt && !is_read && calibration_busy && busy_chk |=> flags_reg.busy_write)
    else $error("write during calibration not flagged");
  AST_COUNT_GATE: assert property (
    !framing_on |=> !$rose(flags_reg.clock_count_flag) && !$rose(flags_reg.invalid_read))
    else $error("framed check raised without select framing");
  AST_COUNT_FLAG: assert property (
    frame_end && frame_clocked && clk_chk && (total_reg[2:0] != 3'h0)
      |=> flags_reg.clock_count_flag [*2])
    else $error("odd clock count not flagged");
  AST_SHORT_WRITE: assert property (
    !word_evt |=> $stable(err_en_reg) && $stable(ctrl_reg))
    else $error("register changed without a complete word");
  AST_BAD_READ: assert property (
    word_evt && is_read && !is_readable(w_addr) && rd_chk |=> flags_reg.invalid_read)
    else $error("invalid read not flagged");
  AST_WR_GATE: assert property (
    !wr_chk |=> !$rose(flags_reg.invalid_write))
    else $error("invalid write flagged while check inactive");
  AST_BAD_WRITE: assert property (
    word_evt && !is_read && !busy && !is_writable(w_addr) && wr_chk
      |=> flags_reg.invalid_write ##1 $stable(err_en_reg))
    else $error("invalid write not flagged");
  AST_STICKY: assert property (
    flags_reg.clock_count_flag && !clr_v |=> flags_reg.clock_count_flag)
    else $error("flag dropped without a read of the error register");

  CVR_WRITE: cover property (do_write && (w_addr == spf_pkg::ADDR_ERROR_ENABLE));
  CVR_BUSY: cover property ($rose(flags_reg.busy_write));
  CVR_COUNT: cover property ($rose(flags_reg.clock_count_flag));
  CVR_CLEAR: cover property (clr_v && (flags_reg != '0));

endmodule

// *** spf_host_model.sv ***
// Purpose: Serial host model that runs one framed register access per call.
// Assumes: Mode 3 link, 15 ns period, clock stands still outside frames.
// Notes: The data line shows the inverse of its last bit when not carrying data,
//   so a device that samples outside the data clocks cannot pass by luck.
module spf_host_model (
  // Link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Clocks past 24 carry junk; a bit read while not driven comes back unknown
  task automatic xfer(input int n, input logic [23:0] w, output logic [15:0] r);
    r = 16'h0000;
    // Off the clk grid, so no select or clock edge lands on a clk edge
    #3.3;
    cs_n = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      mosi = (i < 24) ? w[23 - i] : ~mosi;
      #7.5;
      sclk = 1'b1;
      if (i >= 8 && i < 24) begin
        r = {r[14:0], (miso_oe_n === 1'b0) ? miso : 1'bx};
      end
      #7.5;
    end
    #10;
    cs_n = 1'b1;
    mosi = ~mosi;
    #40;
  endtask
endmodule

// *** serial_port_error_checks_bench.sv ***
// Purpose: Self-checking bench for the serial-port error checks.
// Assumes: One access per frame; results settle within 8 clk after a frame.
// Notes: Expected register and flag state is kept in a shadow updated per access.
module serial_port_error_checks_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe_n;
  logic fuse_copy_busy = 1'b0;
  logic calibration_busy = 1'b0;
  spf_pkg::spf_flags_s error_flags;
  logic [15:0] error_report_enable, control_word, en_exp, ctl_exp, rd;
  logic [3:0] fl_exp;
  logic [31:0] r;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int cnt[4] = '{7, 16, 25, 40};

  always #4 clk = ~clk;

  spf_error_checks dut_u (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n), .fuse_copy_busy(fuse_copy_busy),
    .calibration_busy(calibration_busy), .error_flags(error_flags),
    .error_report_enable(error_report_enable), .control_word(control_word));
  spf_host_model host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // About 64 clk per 24-clock access, 79 per 32-clock; well above the planned run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  function automatic logic [15:0] read_exp(input logic [5:0] a, input logic f, input logic c);
    case (a)
      spf_pkg::ADDR_CONTROL: return ctl_exp;
      spf_pkg::ADDR_BUSY_STATUS: return {14'h0000, c, f};
      spf_pkg::ADDR_ERROR: return {9'h000, fl_exp, 3'h0};
      spf_pkg::ADDR_ERROR_ENABLE: return en_exp;
      default: return 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // One access with busy levels held across it, then shadow update
  // ----------------------------------------------------------------
  task automatic access(input logic rw, input logic [5:0] a, input logic [15:0] d,
      input int n, input logic f, input logic c);
    logic framed;
    logic [15:0] exp_rd;
    @(posedge clk);
    fuse_copy_busy <= f;
    calibration_busy <= c;
    @(posedge clk);
    framed = ctl_exp[spf_pkg::CTRL_FRAMING_BIT];
    exp_rd = read_exp(a, f, c);
    host_u.xfer(n, {1'b0, rw, a, d}, rd);
    repeat (8) @(posedge clk);
    @(negedge clk);
    if (n >= 24 && rw) begin
      check(rd, exp_rd);
      if (a == spf_pkg::ADDR_ERROR) fl_exp = 4'h0;
      else if (!(a inside {spf_pkg::ADDR_CONTROL, spf_pkg::ADDR_BUSY_STATUS,
          spf_pkg::ADDR_ERROR_ENABLE})) fl_exp[1] |= framed & en_exp[4];
    end else if (n >= 24) begin
      if (f || c) fl_exp[3] |= en_exp[6];
      else if (a == spf_pkg::ADDR_CONTROL) ctl_exp = d;
      else if (a == spf_pkg::ADDR_ERROR_ENABLE) en_exp = d;
      else fl_exp[0] |= framed & en_exp[3];
    end
    if (n % 8 != 0) fl_exp[2] |= framed & en_exp[5];
    check(error_report_enable, en_exp);
    check(control_word, ctl_exp);
    check({12'h000, error_flags}, {12'h000, fl_exp});
    check({14'h0000, miso, miso_oe_n}, 16'h0001);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(71880));
    en_exp = 16'h0040;
    ctl_exp = 16'h0000;
    fl_exp = 4'h0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(error_report_enable, 16'h0040);
    check(control_word, 16'h0000);
    check({12'h000, error_flags}, 16'h0000);
    access(1'b0, spf_pkg::ADDR_CONTROL, 16'h0100, 24, 1'b1, 1'b0);
    access(1'b1, spf_pkg::ADDR_ERROR, 16'h0000, 24, 1'b0, 1'b0);
    access(1'b0, spf_pkg::ADDR_CONTROL, 16'h0100, 24, 1'b0, 1'b1);
    access(1'b1, spf_pkg::ADDR_BUSY_STATUS, 16'h0000, 24, 1'b1, 1'b1);
    access(1'b1, spf_pkg::ADDR_ERROR, 16'h0000, 24, 1'b0, 1'b0);
    // Checks enabled with framing off must stay silent
    access(1'b0, spf_pkg::ADDR_ERROR_ENABLE, 16'h0038, 24, 1'b0, 1'b0);
    access(1'b0, 6'h30, 16'h1234, 24, 1'b0, 1'b0);
    access(1'b1, 6'h21, 16'h0000, 25, 1'b0, 1'b0);
    access(1'b0, spf_pkg::ADDR_CONTROL, 16'h0100, 32, 1'b0, 1'b0);
    // Short write is dropped, odd counts flagged
    access(1'b0, spf_pkg::ADDR_ERROR_ENABLE, 16'h0000, 20, 1'b0, 1'b0);
    access(1'b1, spf_pkg::ADDR_ERROR, 16'h0000, 24, 1'b0, 1'b0);
    foreach (cnt[i]) access(1'b1, spf_pkg::ADDR_CONTROL, 16'h0000, cnt[i], 1'b0, 1'b0);
    access(1'b1, 6'h3f, 16'h0000, 24, 1'b0, 1'b0);
    access(1'b0, spf_pkg::ADDR_BUSY_STATUS, 16'hffff, 24, 1'b0, 1'b0);
    access(1'b1, spf_pkg::ADDR_ERROR, 16'h0000, 24, 1'b0, 1'b0);
    access(1'b0, spf_pkg::ADDR_ERROR, 16'hffff, 24, 1'b0, 1'b0);
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      access(r[0], r[6:1], r[22:7], r[23] ? 24 : 32, r[25:24] == 2'h0, r[27:26] == 2'h0);
    end
    give_verdict();
  end
endmodule
